// [cshs_pkg.sv]
package cshs_pkg;

    // Register byte offsets on the AHB-Lite bus
    localparam logic [11:0] CSHS_OFF_CTRL = 12'h000;
    localparam logic [11:0] CSHS_OFF_IRQ_STATUS = 12'h004;
    localparam logic [11:0] CSHS_OFF_IRQ_MASK = 12'h008;

    // Field positions of clock_switch_control_status
    localparam int CSHS_BIT_HOLD = 7;
    localparam int CSHS_BIT_PWR = 6;
    localparam int CSHS_BIT_CUR_RDY = 4;
    localparam int CSHS_BIT_NEW_RDY = 3;

    // Field positions of the interrupt status and mask registers
    localparam int CSHS_IRQ_HOLD = 0;
    localparam int CSHS_IRQ_DONE = 1;
    localparam int CSHS_IRQ_ABORT = 2;
    localparam int CSHS_IRQ_BITS = 3;

    // Width of the oscillator selection code
    localparam int CSHS_SEL_W = 3;

    // Values after reset
    localparam logic CSHS_RST_HOLD = 1'b0;
    localparam logic CSHS_RST_PWR = 1'b0;
    localparam logic [CSHS_SEL_W-1:0] CSHS_RST_OSC = 3'h0;
    localparam logic [CSHS_IRQ_BITS-1:0] CSHS_RST_MASK = 3'h0;
    localparam logic [31:0] CSHS_RST_RDATA = 32'h0000_0000;

    // Synchroniser depth in cycles
    localparam int CSHS_SYNC_STAGES = 2;

    // AHB transfer type bit that marks an active transfer
    localparam int CSHS_HTRANS_ACTIVE = 1;

    // Switch sequencer states, Gray coded along idle, wait, hold
    typedef enum logic [1:0] {
        CSHS_IDLE = 2'b00,
        CSHS_WAIT = 2'b01,
        CSHS_HOLD = 2'b11
    } cshs_state_t;

endpackage

// [cshs_sync.sv]
module cshs_sync
    import cshs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Level from another domain
    output logic [WIDTH-1:0] sync_out // Level safe to use on hclk
);

    logic [WIDTH-1:0] meta;

    // Two flops; only the second one reads the first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// [cshs_flag.sv]
module cshs_flag (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic set, // Event pulse from hardware
    input wire logic clr, // Write-one-to-clear pulse from software
    output logic flag // Sticky flag
);

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag <= 1'b0;
        end else begin
            flag <= set | (flag & ~clr);
        end
    end

endmodule

// [cshs_top.sv]
// Notes on behaviour
// - Hold bit set: stall the switch once new oscillator ready, raise interrupt.
// - Power select bit: one gives high-power, zero low-power secondary oscillator.
// - Current-ready flag: one when clock matches selection, zero mid-switch.
// - New-ready flag: one only while switching and selected oscillator ready.
module cshs_top
    import cshs_pkg::*;
(
    input wire logic hclk, // System clock, 50 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write when high
    input wire logic [2:0] hsize, // AHB size, words only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // Slave ready, always high
    output logic hresp, // Slave response, always OKAY
    output logic [31:0] hrdata, // AHB read data
    input wire logic [CSHS_SEL_W-1:0] new_osc_select, // Requested clock
    input wire logic osc_ready_raw, // Selected oscillator ready, async
    output logic [CSHS_SEL_W-1:0] current_osc, // Clock now in use
    output logic switch_in_progress, // High while a switch is pending
    output logic switch_commit, // Pulse: move system clock now
    output logic secondary_osc_high_power, // Secondary osc power mode
    output logic irq // Level interrupt, unmasked status set
);

    cshs_state_t state;
    cshs_state_t next_state;
    logic osc_ready;
    logic switch_hold_ctl;
    logic secondary_osc_power_sel;
    logic [CSHS_IRQ_BITS-1:0] irq_mask;
    logic [CSHS_IRQ_BITS-1:0] irq_status;
    logic [CSHS_IRQ_BITS-1:0] irq_set;
    logic [CSHS_IRQ_BITS-1:0] irq_clr;
    logic wr_pend;
    logic rd_pend;
    logic [11:0] addr_q;
    logic addr_phase;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic differ;
    logic do_hold;
    logic do_commit;
    logic do_abort;
    logic current_osc_ready_flag;
    logic new_osc_ready_flag;
    logic [7:0] ctrl_rd;

    // Oscillator ready comes from the analog unit, so it is synchronised
    cshs_sync #(
        .WIDTH(1)
    ) u_sync_ready (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(osc_ready_raw),
        .sync_out(osc_ready)
    );

    // Bus is never stalled and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel & htrans[CSHS_HTRANS_ACTIVE] & hready;

    // Capture the address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 12'h000;
        end else if (hready) begin
            wr_pend <= addr_phase & hwrite;
            rd_pend <= addr_phase & ~hwrite;
            addr_q <= haddr[11:0];
        end
    end

    // Write strobes act in the data phase, when hwdata stands
    assign wr_ctrl = wr_pend & (addr_q == CSHS_OFF_CTRL);
    assign wr_stat = wr_pend & (addr_q == CSHS_OFF_IRQ_STATUS);
    assign wr_mask = wr_pend & (addr_q == CSHS_OFF_IRQ_MASK);

    // Sequencer decode
    assign differ = (new_osc_select != current_osc);
    assign do_abort = (state != CSHS_IDLE) & ~differ;
    assign do_hold = (state == CSHS_WAIT) & differ & osc_ready
        & switch_hold_ctl;
    assign do_commit = differ & ~switch_hold_ctl
        & (((state == CSHS_WAIT) & osc_ready)
        | (state == CSHS_HOLD));

    // Next state of the switch sequencer
    always_comb begin
        next_state = state;
        case (state)
            CSHS_IDLE: begin
                if (differ) begin
                    next_state = CSHS_WAIT;
                end
            end
            CSHS_WAIT: begin
                if (do_abort || do_commit) begin
                    next_state = CSHS_IDLE;
                end else if (do_hold) begin
                    next_state = CSHS_HOLD;
                end
            end
            CSHS_HOLD: begin
                if (do_abort || do_commit) begin
                    next_state = CSHS_IDLE;
                end
            end
            default: begin
                next_state = CSHS_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= CSHS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Current clock follows the request only on commit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            current_osc <= CSHS_RST_OSC;
            switch_commit <= 1'b0;
        end else begin
            switch_commit <= do_commit;
            if (do_commit) begin
                current_osc <= new_osc_select;
            end
        end
    end

    // Hold bit: software sets, hardware clears when a switch is dropped;
    // a software write in the same cycle wins so a new hold is not lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            switch_hold_ctl <= CSHS_RST_HOLD;
        end else if (wr_ctrl) begin
            switch_hold_ctl <= hwdata[CSHS_BIT_HOLD];
        end else if (do_abort) begin
            switch_hold_ctl <= 1'b0;
        end
    end

    // Secondary oscillator power mode, drives the oscillator directly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            secondary_osc_power_sel <= CSHS_RST_PWR;
        end else if (wr_ctrl) begin
            secondary_osc_power_sel <= hwdata[CSHS_BIT_PWR];
        end
    end
    assign secondary_osc_high_power = secondary_osc_power_sel;

    // Status flags are derived, so writes cannot touch them
    assign switch_in_progress = (state != CSHS_IDLE);
    assign current_osc_ready_flag = ~switch_in_progress & ~differ;
    assign new_osc_ready_flag = switch_in_progress & osc_ready;

    // Interrupt mask register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= CSHS_RST_MASK;
        end else if (wr_mask) begin
            irq_mask <= hwdata[CSHS_IRQ_BITS-1:0];
        end
    end

    // Events: hold reached, switch done, switch dropped
    assign irq_set[CSHS_IRQ_HOLD] = do_hold;
    assign irq_set[CSHS_IRQ_DONE] = do_commit;
    assign irq_set[CSHS_IRQ_ABORT] = do_abort;
    assign irq_clr = wr_stat ? hwdata[CSHS_IRQ_BITS-1:0] : '0;

    // One sticky flag per event
    for (genvar i = 0; i < CSHS_IRQ_BITS; i++) begin : g_flag
        cshs_flag u_flag (
            .hclk(hclk),
            .hresetn(hresetn),
            .set(irq_set[i]),
            .clr(irq_clr[i]),
            .flag(irq_status[i])
        );
    end

    // Level interrupt; combinational from the status and mask flops, not registered
    assign irq = |(irq_status & irq_mask);

    // Control register view; unimplemented bits read zero
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[CSHS_BIT_HOLD] = switch_hold_ctl;
        ctrl_rd[CSHS_BIT_PWR] = secondary_osc_power_sel;
        ctrl_rd[CSHS_BIT_CUR_RDY] = current_osc_ready_flag;
        ctrl_rd[CSHS_BIT_NEW_RDY] = new_osc_ready_flag;
    end

    // Read mux in the data phase, so a read right after a write sees it;
    // it selects flops and the derived ready flags, unmapped addresses read zero
    always_comb begin
        hrdata = CSHS_RST_RDATA;
        if (rd_pend) begin
            case (addr_q)
                CSHS_OFF_CTRL: begin
                    hrdata = {24'h00_0000, ctrl_rd};
                end
                CSHS_OFF_IRQ_STATUS: begin
                    hrdata = {29'h0, irq_status};
                end
                CSHS_OFF_IRQ_MASK: begin
                    hrdata = {29'h0, irq_mask};
                end
                default: begin
                    hrdata = CSHS_RST_RDATA;
                end
            endcase
        end
    end

    // Checks on the sequencer and register file
    property p_hold_stall;
        @(posedge hclk) disable iff (!hresetn)
        do_hold && !wr_stat |=> state == CSHS_HOLD
            && irq_status[CSHS_IRQ_HOLD] && current_osc == $past(current_osc);
    endproperty
    a_hold_stall: assert property (p_hold_stall)
        else $error("hold not entered or flag not set");

    property p_hold_keeps;
        @(posedge hclk) disable iff (!hresetn)
        state == CSHS_HOLD && switch_hold_ctl && differ
            |=> current_osc == $past(current_osc) && !switch_commit;
    endproperty
    a_hold_keeps: assert property (p_hold_keeps)
        else $error("held switch went ahead");

    property p_release;
        @(posedge hclk) disable iff (!hresetn)
        state == CSHS_HOLD && !switch_hold_ctl && differ
            |=> state == CSHS_IDLE && current_osc == $past(new_osc_select)
            && switch_commit;
    endproperty
    a_release: assert property (p_release)
        else $error("released switch did not complete");

    property p_power;
        @(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> secondary_osc_high_power == $past(hwdata[CSHS_BIT_PWR]);
    endproperty
    a_power: assert property (p_power)
        else $error("power mode did not follow write");

    property p_cur_ready;
        @(posedge hclk) disable iff (!hresetn)
        differ [*2] |-> !current_osc_ready_flag;
    endproperty
    a_cur_ready: assert property (p_cur_ready)
        else $error("ready flag set during switch");

    property p_new_ready;
        @(posedge hclk) disable iff (!hresetn)
        new_osc_ready_flag |-> switch_in_progress && osc_ready;
    endproperty
    a_new_ready: assert property (p_new_ready)
        else $error("new ready flag set outside switch");

    property p_read_zero;
        @(posedge hclk) disable iff (!hresetn)
        rd_pend && addr_q == CSHS_OFF_CTRL
            |-> hrdata[31:8] == 24'h00_0000 && hrdata[5] == 1'b0
            && hrdata[2:0] == 3'h0;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("unimplemented bits not zero");

    property p_hw_clear;
        @(posedge hclk) disable iff (!hresetn)
        do_abort && !wr_ctrl |=> !switch_hold_ctl && state == CSHS_IDLE;
    endproperty
    a_hw_clear: assert property (p_hw_clear)
        else $error("hold bit not cleared on drop");

    property p_cov_hold;
        @(posedge hclk) disable iff (!hresetn)
        state == CSHS_HOLD && irq;
    endproperty
    c_hold: cover property (p_cov_hold);

    property p_cov_release;
        @(posedge hclk) disable iff (!hresetn)
        state == CSHS_HOLD ##1 switch_commit;
    endproperty
    c_release: cover property (p_cov_release);

    property p_cov_direct;
        @(posedge hclk) disable iff (!hresetn)
        state == CSHS_WAIT && do_commit;
    endproperty
    c_direct: cover property (p_cov_direct);

endmodule

// [tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cshs_pkg::*;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [CSHS_SEL_W-1:0] new_osc_select = 3'h0;
    logic osc_ready_raw = 1'b0;
    logic [CSHS_SEL_W-1:0] current_osc;
    logic switch_in_progress;
    logic switch_commit;
    logic secondary_osc_high_power;
    logic irq;
    int num_errors = 0;
    int num_checks = 0;

    // Single slave, so its ready closes the loop as the bus ready
    cshs_top u_cshs_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .new_osc_select(new_osc_select),
        .osc_ready_raw(osc_ready_raw), .current_osc(current_osc),
        .switch_in_progress(switch_in_progress),
        .switch_commit(switch_commit),
        .secondary_osc_high_power(secondary_osc_high_power), .irq(irq)
    );

    // 50 MHz system clock
    always #10 hclk = ~hclk;

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait for hready; a stuck slave ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                check("hready", 32'h1, {31'h0, hreadyout});
                finish_test();
            end
            @(posedge hclk);
        end
    endtask

    // One whole-word transfer: address phase, then data phase
    task automatic bus_xfer(input logic wr, input logic [31:0] addr,
                            input logic [31:0] wdata,
                            output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_ready();
        rdata = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(1'b1, {20'h0, addr}, d, dummy);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] addr,
                          input logic [31:0] exp);
        logic [31:0] d;
        bus_xfer(1'b0, {20'h0, addr}, 32'h0, d);
        check(name, exp, d);
    endtask

    // Polls the commit pulse; it only stands one cycle
    task automatic wait_commit();
        int n;
        n = 0;
        @(posedge hclk);
        while (switch_commit !== 1'b1) begin
            n++;
            if (n > 32) begin
                check("switch_commit", 32'h1, {31'h0, switch_commit});
                finish_test();
            end
            @(posedge hclk);
        end
    endtask

    task automatic t_reset();
        rd_chk("ctrl reset", CSHS_OFF_CTRL, 32'h10);
        rd_chk("status reset", CSHS_OFF_IRQ_STATUS, 32'h0);
        rd_chk("mask reset", CSHS_OFF_IRQ_MASK, 32'h0);
        rd_chk("unmapped", 12'h00c, 32'h0);
        check("power reset", 32'h0, {31'h0, secondary_osc_high_power});
    endtask

    task automatic t_power();
        wr(CSHS_OFF_CTRL, 32'h40);
        rd_chk("ctrl pwr", CSHS_OFF_CTRL, 32'h50);
        check("power high", 32'h1, {31'h0, secondary_osc_high_power});
        // Status bits are read-only: ones written there must not stick
        wr(CSHS_OFF_CTRL, 32'h3f);
        rd_chk("ctrl ro", CSHS_OFF_CTRL, 32'h10);
        check("power low", 32'h0, {31'h0, secondary_osc_high_power});
        wr(12'h00c, 32'hff);
        rd_chk("unmapped wr", 12'h00c, 32'h0);
    endtask

    task automatic t_switch();
        new_osc_select <= 3'h1;
        repeat (3) @(posedge hclk);
        rd_chk("ctrl waiting", CSHS_OFF_CTRL, 32'h00);
        check("in progress", 32'h1, {31'h0, switch_in_progress});
        osc_ready_raw <= 1'b1;
        wait_commit();
        check("current osc", 32'h1, {29'h0, current_osc});
        rd_chk("ctrl done", CSHS_OFF_CTRL, 32'h10);
        rd_chk("status done", CSHS_OFF_IRQ_STATUS, 32'h2);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(CSHS_OFF_IRQ_STATUS, 32'h7);
        rd_chk("status clr", CSHS_OFF_IRQ_STATUS, 32'h0);
        osc_ready_raw <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic t_hold();
        int n;
        wr(CSHS_OFF_IRQ_MASK, 32'h7);
        rd_chk("mask rw", CSHS_OFF_IRQ_MASK, 32'h7);
        wr(CSHS_OFF_CTRL, 32'h80);
        new_osc_select <= 3'h2;
        osc_ready_raw <= 1'b1;
        n = 0;
        @(posedge hclk);
        while (irq !== 1'b1) begin
            n++;
            if (n > 32) begin
                check("hold irq", 32'h1, {31'h0, irq});
                finish_test();
            end
            @(posedge hclk);
        end
        // Stall must persist well past the ready point
        repeat (8) @(posedge hclk);
        check("held osc", 32'h1, {29'h0, current_osc});
        rd_chk("ctrl held", CSHS_OFF_CTRL, 32'h88);
        rd_chk("status held", CSHS_OFF_IRQ_STATUS, 32'h1);
        wr(CSHS_OFF_CTRL, 32'h00);
        wait_commit();
        check("released osc", 32'h2, {29'h0, current_osc});
        rd_chk("status rel", CSHS_OFF_IRQ_STATUS, 32'h3);
        wr(CSHS_OFF_IRQ_STATUS, 32'h7);
        // The clear lands on the edge that closes the write, so look later
        @(posedge hclk);
        check("irq clear", 32'h0, {31'h0, irq});
        osc_ready_raw <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic t_abort();
        wr(CSHS_OFF_CTRL, 32'h80);
        new_osc_select <= 3'h3;
        repeat (3) @(posedge hclk);
        rd_chk("ctrl pend", CSHS_OFF_CTRL, 32'h80);
        new_osc_select <= 3'h2;
        repeat (3) @(posedge hclk);
        // Dropped switch: hold bit is cleared by hardware
        rd_chk("ctrl abort", CSHS_OFF_CTRL, 32'h10);
        rd_chk("status abort", CSHS_OFF_IRQ_STATUS, 32'h4);
        check("irq abort", 32'h1, {31'h0, irq});
        check("osc kept", 32'h2, {29'h0, current_osc});
        wr(CSHS_OFF_IRQ_STATUS, 32'h4);
        @(posedge hclk);
        check("irq off", 32'h0, {31'h0, irq});
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_power();
        t_switch();
        t_hold();
        t_abort();
        finish_test();
    end
endmodule
